/* File: rtl/idl_pkg.sv */
// Purpose: Shared constants for the two-wire converter code loader
// Assumes: Seven-bit addressing, byte transfers with a ninth ack clock
// Notes: Device side runs on the serial clock, master side on clk
package idl_pkg;
    localparam logic [5:0] ADDR_UPPER = 6'h26;
    localparam int BYTE_BITS = 8;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CLK_NS = 8;
    // Fast rate; the slower rates only stretch the same sequence
    localparam int SCL_HALF_NS = 1250;
    // Fast-rate half period rounds down, at least one cycle
    localparam int SCL_HALF_CYC = (SCL_HALF_NS / CLK_NS) < 1 ? 1 :
        (SCL_HALF_NS / CLK_NS);
    typedef enum logic [1:0] {
        IDL_SL_IDLE = 2'b00,
        IDL_SL_ADDR = 2'b01,
        IDL_SL_WRITE = 2'b10,
        IDL_SL_READ = 2'b11
    } idl_slave_st_t;
    typedef enum logic [3:0] {
        IDL_M_IDLE = 4'h0,
        IDL_M_START = 4'h1,
        IDL_M_BIT_LO = 4'h2,
        IDL_M_BIT_HI = 4'h3,
        IDL_M_NEXT = 4'h4,
        IDL_M_STOP_LO = 4'h5,
        IDL_M_STOP_HI = 4'h6,
        IDL_M_STOP_END = 4'h7
    } idl_mst_st_t;
endpackage

/* File: rtl/idl_bus_if.sv */
// Purpose: Two-wire link between master and converter code loader
// Assumes: Open-drain wires; low enable means the party pulls low
// Notes: The wire is high unless some party's enable is low
`timescale 1ns/1ns
interface idl_bus_if;
    logic scl_oe_n_m;
    logic sda_oe_n_m;
    logic sda_oe_n_s;
    logic scl;
    logic sda;
    assign scl = scl_oe_n_m;
    assign sda = sda_oe_n_m & sda_oe_n_s;
    modport master (
        output scl_oe_n_m,
        output sda_oe_n_m,
        input scl,
        input sda
    );
    modport slave (
        output sda_oe_n_s,
        input scl,
        input sda
    );
endinterface

/* File: rtl/idl_slave.sv */
// Purpose: Slave end that loads 16-bit codes from the two-wire bus
// Assumes: Clocked by the serial clock; start/stop seen on data edges
// Notes: Code output is a level in the serial clock domain
// Function
// - Code is unsigned, full 16-bit range
// - Only pull data low or release
// - Works at all three bus rates
// - Slave only, never drives clock
// - Master makes clock, conditions, addressing
// - Ninth clock carries acknowledge low
// - Released data on ninth is nack
// - Start is data fall, clock high
// - Data changes only while clock low
// - Address 100110 plus select pin
// - Acknowledge matching address
// - Acknowledge control byte after address
// - Acknowledge upper code byte
// - Acknowledge lower code byte
// - Update code at ack falling edge
// - Byte pairs repeat without control
// - Stop is data rise, clock high
// - Ignore bus until start and match
// - Stop keeps code and mode
// - Read makes device transmit registers
// - Read order high, low, control
// - Master uses repeated start (idl_master instead ends each transfer with stop, then a new start)
`timescale 1ns/1ns
module idl_slave (
    idl_bus_if.slave bus,
    input wire logic rst_n,
    input wire logic address_select_pin,
    output logic [15:0] dac_code,
    output logic [7:0] ctrl_byte,
    output logic load_pulse
);
    wire scl = bus.scl;
    logic start_tog_q, stop_tog_q;
    logic start_seen_q, stop_seen_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] sh_q;
    logic [7:0] upper_q;
    logic [1:0] wbyte_q;
    logic [1:0] rbyte_q;
    logic ack_q, tx_q, drive_q;
    logic strap_meta_q;
    logic strap_q;
    logic [7:0] lo_q;
    logic lo_done_q;
    logic [7:0] rd_cur;
    idl_pkg::idl_slave_st_t st_q;
    logic [15:0] code_q;
    logic [7:0] ctrl_q;
    logic load_q;
    logic started, stopped;
    // Start detect, held until next scl rise
    always_ff @(negedge bus.sda or negedge rst_n)
    begin
        if (!rst_n)
            start_tog_q <= 1'b0;
        else if (scl)
            start_tog_q <= ~start_tog_q;
    end
    always_ff @(posedge bus.sda or negedge rst_n)
    begin
        if (!rst_n)
            stop_tog_q <= 1'b0;
        else if (scl)
            stop_tog_q <= ~stop_tog_q;
    end
    assign started = start_tog_q != start_seen_q;
    assign stopped = stop_tog_q != stop_seen_q;
    // Strap pin passes two flops; settled long before the address compare
    always_ff @(posedge scl)
    begin
        if (!rst_n)
        begin
            strap_meta_q <= 1'b0;
            strap_q <= 1'b0;
        end
        else
        begin
            strap_meta_q <= address_select_pin;
            strap_q <= strap_meta_q;
        end
    end
    always_ff @(posedge scl)
    begin
        if (!rst_n)
        begin
            st_q <= idl_pkg::IDL_SL_IDLE;
            bit_cnt_q <= 4'h0;
            sh_q <= 8'h00;
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
            wbyte_q <= 2'd0;
        end
        else
        begin
            start_seen_q <= start_tog_q;
            stop_seen_q <= stop_tog_q;
            if (started)
            begin
                st_q <= idl_pkg::IDL_SL_ADDR;
                bit_cnt_q <= 4'h1;
                sh_q <= {7'h00, bus.sda};
                wbyte_q <= 2'd0;
            end
            else if (stopped || st_q == idl_pkg::IDL_SL_IDLE)
                st_q <= idl_pkg::IDL_SL_IDLE;
            else if (bit_cnt_q == 4'd8)
            begin
                bit_cnt_q <= 4'h0;
                if (st_q == idl_pkg::IDL_SL_ADDR)
                begin
                    if (sh_q[7:1] != {idl_pkg::ADDR_UPPER, strap_q})
                        st_q <= idl_pkg::IDL_SL_IDLE;
                    else if (sh_q[0])
                        st_q <= idl_pkg::IDL_SL_READ;
                    else
                        st_q <= idl_pkg::IDL_SL_WRITE;
                end
                else if (st_q == idl_pkg::IDL_SL_READ && bus.sda)
                    st_q <= idl_pkg::IDL_SL_IDLE;
                else if (st_q == idl_pkg::IDL_SL_WRITE)
                    wbyte_q <= (wbyte_q == 2'd3) ? 2'd2 : wbyte_q + 2'd1;
            end
            else
            begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                sh_q <= {sh_q[6:0], bus.sda};
            end
        end
    end
    // Capture bytes on the eighth bit, write direction
    always_ff @(posedge scl)
    begin
        if (!rst_n)
        begin
            ctrl_q <= idl_pkg::CTRL_RESET;
            upper_q <= 8'h00;
        end
        else if (st_q == idl_pkg::IDL_SL_WRITE && bit_cnt_q == 4'd7
                 && !started)
        begin
            if (wbyte_q == 2'd0)
                ctrl_q <= {sh_q[6:0], bus.sda};
            else if (wbyte_q == 2'd1 || wbyte_q == 2'd3)
                upper_q <= {sh_q[6:0], bus.sda};
        end
    end
    // Ack phase and transmit drive change on the falling edge
    always_ff @(negedge scl)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            tx_q <= 1'b1;
            rbyte_q <= 2'd0;
            code_q <= idl_pkg::CODE_RESET;
            load_q <= 1'b0;
            drive_q <= 1'b0;
        end
        else
        begin
            load_q <= 1'b0;
            // Whole 16-bit code loaded
            // The ninth rise of a low byte has already moved wbyte_q to 3
            if (ack_q && st_q == idl_pkg::IDL_SL_WRITE && wbyte_q == 2'd3
                && lo_done_q)
            begin
                code_q <= {upper_q, lo_q};
                load_q <= 1'b1;
            end
            ack_q <= (bit_cnt_q == 4'd8) && !started &&
                ((st_q == idl_pkg::IDL_SL_ADDR &&
                  sh_q[7:1] == {idl_pkg::ADDR_UPPER, strap_q}) ||
                 st_q == idl_pkg::IDL_SL_WRITE);
            if (st_q == idl_pkg::IDL_SL_READ && bit_cnt_q < 4'd8)
            begin
                drive_q <= 1'b1;
                tx_q <= rd_cur[3'd7 - bit_cnt_q[2:0]];
                if (bit_cnt_q == 4'd7)
                    rbyte_q <= (rbyte_q == 2'd2) ? 2'd0 : rbyte_q + 2'd1;
            end
            else
            begin
                drive_q <= 1'b0;
                tx_q <= 1'b1;
                if (st_q != idl_pkg::IDL_SL_READ)
                    rbyte_q <= 2'd0;
            end
        end
    end
    // Lower byte captured with a flag for the following ack fall
    always_ff @(posedge scl)
    begin
        if (!rst_n)
        begin
            lo_q <= 8'h00;
            lo_done_q <= 1'b0;
        end
        else if (st_q == idl_pkg::IDL_SL_WRITE && bit_cnt_q == 4'd7
                 && wbyte_q[0] == 1'b0 && wbyte_q != 2'd0 && !started)
        begin
            lo_q <= {sh_q[6:0], bus.sda};
            lo_done_q <= 1'b1;
        end
        else if (bit_cnt_q == 4'd0)
            lo_done_q <= 1'b0;
    end
    function automatic logic [7:0] rd_byte(input logic [1:0] b);
        case (b)
            2'd0: rd_byte = code_q[15:8];
            2'd1: rd_byte = code_q[7:0];
            default: rd_byte = ctrl_q;
        endcase
    endfunction
    assign rd_cur = rd_byte(rbyte_q);
    // Open drain: enable low only to pull low
    assign bus.sda_oe_n_s = !(ack_q || (drive_q && !tx_q));
    assign dac_code = code_q;
    assign ctrl_byte = ctrl_q;
    assign load_pulse = load_q;
endmodule

/* File: rtl/idl_master.sv */
// Purpose: Bus master end issuing writes and reads to the loader
// Assumes: Bus clock derived from clk by divider, driven out open drain
// Notes: One transfer per request; ack_ok goes low if any loader ack in the transfer was missed
`timescale 1ns/1ns
module idl_master (
    idl_bus_if.master bus,
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic rd,
    input wire logic [6:0] addr,
    input wire logic [7:0] ctrl,
    input wire logic [15:0] code,
    output logic busy,
    output logic done,
    output logic ack_ok,
    output logic [23:0] rd_data
);
    localparam int HC = idl_pkg::SCL_HALF_CYC;
    idl_pkg::idl_mst_st_t st_q;
    logic [15:0] div_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] tx_q;
    logic rd_q, scl_q, sda_q, ack_q, done_q, any_nack_q;
    logic [7:0] ctrl_q;
    logic [15:0] code_q;
    logic [23:0] rx_q;
    logic [1:0] sda_s;
    logic tick;
    assign tick = div_q == 16'(HC - 1);
    // Pin input through two flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sda_s <= 2'b11;
        else
            sda_s <= {sda_s[0], bus.sda};
    end
    function automatic logic [7:0] pick(input logic r, input logic [1:0] b,
        input logic [6:0] a, input logic [7:0] c, input logic [15:0] d);
        if (b == 2'd0)
            pick = {a, r};
        else if (b == 2'd1)
            pick = c;
        else if (b == 2'd2)
            pick = d[15:8];
        else
            pick = d[7:0];
    endfunction
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= idl_pkg::IDL_M_IDLE;
            div_q <= 16'h0000;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_q <= 4'h0;
            byte_q <= 2'd0;
            tx_q <= 8'h00;
            rd_q <= 1'b0;
            ctrl_q <= 8'h00;
            code_q <= 16'h0000;
            rx_q <= 24'h000000;
            done_q <= 1'b0;
            any_nack_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            div_q <= (tick || st_q == idl_pkg::IDL_M_IDLE) ? 16'h0000 :
                div_q + 16'h0001;
            case (st_q)
                idl_pkg::IDL_M_IDLE:
                    if (req)
                    begin
                        rd_q <= rd;
                        ctrl_q <= ctrl;
                        code_q <= code;
                        tx_q <= {addr, rd};
                        byte_q <= 2'd0;
                        bit_q <= 4'h0;
                        any_nack_q <= 1'b0;
                        sda_q <= 1'b0;
                        st_q <= idl_pkg::IDL_M_START;
                    end
                idl_pkg::IDL_M_START:
                    if (tick)
                    begin
                        scl_q <= 1'b0;
                        st_q <= idl_pkg::IDL_M_BIT_LO;
                    end
                idl_pkg::IDL_M_BIT_LO:
                    if (tick)
                    begin
                        scl_q <= 1'b1;
                        st_q <= idl_pkg::IDL_M_BIT_HI;
                    end
                    else if (div_q == 16'(HC / 2))
                    begin
                        if (bit_q == 4'd8)
                            // Master acks read bytes; nack last
                            sda_q <= !(rd_q && byte_q != 2'd0 &&
                                byte_q != 2'd3);
                        else if (rd_q && byte_q != 2'd0)
                            sda_q <= 1'b1;
                        else
                            sda_q <= tx_q[3'd7 - bit_q[2:0]];
                    end
                idl_pkg::IDL_M_BIT_HI:
                    if (tick)
                    begin
                        scl_q <= 1'b0;
                        if (bit_q == 4'd8)
                        begin
                            bit_q <= 4'h0;
                            st_q <= idl_pkg::IDL_M_NEXT;
                        end
                        else
                        begin
                            bit_q <= bit_q + 4'h1;
                            st_q <= idl_pkg::IDL_M_BIT_LO;
                        end
                    end
                    else if (div_q == 16'(HC / 2))
                    begin
                        if (bit_q == 4'd8 && !(rd_q && byte_q != 2'd0))
                            any_nack_q <= any_nack_q | sda_s[1];
                        else if (bit_q != 4'd8 && rd_q && byte_q != 2'd0)
                            rx_q <= {rx_q[22:0], sda_s[1]};
                    end
                idl_pkg::IDL_M_NEXT:
                    if (any_nack_q || byte_q == 2'd3)
                        st_q <= idl_pkg::IDL_M_STOP_LO;
                    else
                    begin
                        byte_q <= byte_q + 2'd1;
                        tx_q <= pick(rd_q, byte_q + 2'd1, 7'h00, ctrl_q,
                            code_q);
                        st_q <= idl_pkg::IDL_M_BIT_LO;
                    end
                idl_pkg::IDL_M_STOP_LO:
                    if (tick)
                    begin
                        scl_q <= 1'b1;
                        st_q <= idl_pkg::IDL_M_STOP_HI;
                    end
                    else if (div_q == 16'(HC / 2))
                        sda_q <= 1'b0;
                idl_pkg::IDL_M_STOP_HI:
                    if (tick)
                    begin
                        sda_q <= 1'b1;
                        st_q <= idl_pkg::IDL_M_STOP_END;
                    end
                idl_pkg::IDL_M_STOP_END:
                    if (tick)
                    begin
                        done_q <= 1'b1;
                        st_q <= idl_pkg::IDL_M_IDLE;
                    end
                default:
                    st_q <= idl_pkg::IDL_M_IDLE;
            endcase
        end
    end
    assign bus.scl_oe_n_m = scl_q;
    assign bus.sda_oe_n_m = sda_q;
    assign busy = st_q != idl_pkg::IDL_M_IDLE;
    assign done = done_q;
    assign ack_ok = !any_nack_q;
    assign rd_data = rx_q;
endmodule

/* File: dv/idl_asserts.sv */
// Purpose: Wire-level checks beside the two-wire code loader link
// Assumes: Sampled on clk, far faster than the serial clock
// Notes: Bit position is rebuilt here from the wires themselves
`timescale 1ns/1ns
module idl_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_oe_n_s,
    input wire logic busy,
    input wire logic done,
    input wire logic load_pulse,
    input wire logic [15:0] dac_code
);
    // Stop to done is one divider period of the master
    localparam int STOP_MAX = 400;
    logic [7:0] rise_cnt_q;
    logic rd_q;
    logic seen_q;
    logic [3:0] pos;
    assign pos = 4'(rise_cnt_q % 8'h09);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Loader outputs stay unknown until its reset meets an scl edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            seen_q <= 1'b0;
        else if (busy && !scl)
            seen_q <= 1'b1;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rise_cnt_q <= 8'h00;
        else if (scl && $fell(sda))
            rise_cnt_q <= 8'h00;
        else if ($rose(scl))
            rise_cnt_q <= rise_cnt_q + 8'h01;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rd_q <= 1'b0;
        else if ($rose(scl) && rise_cnt_q == 8'h07)
            rd_q <= sda;
    end
    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_stop;
        busy && scl && $past(scl) && $rose(sda);
    endsequence
    property p_start_first;
        $rose(busy) |-> s_start;
    endproperty
    property p_idle_free;
        seen_q && !busy |-> scl && sda;
    endproperty
    property p_slave_stable;
        seen_q && scl && $past(scl) |-> $stable(sda_oe_n_s);
    endproperty
    property p_stop_done;
        seen_q ##0 s_stop |-> ##[1:STOP_MAX] $rose(done);
    endproperty
    property p_write_ack_slot;
        seen_q && !rd_q && scl && $past(scl) && !sda_oe_n_s
            |-> pos == 4'h0 && rise_cnt_q != 8'h00;
    endproperty
    property p_read_gives_way;
        seen_q && rd_q && scl && $past(scl) && pos == 4'h0
            && rise_cnt_q >= 8'h12 |-> sda_oe_n_s;
    endproperty
    property p_load_slot;
        seen_q && $rose(load_pulse) |-> !scl && !rd_q
            && rise_cnt_q >= 8'h24 && (rise_cnt_q % 8'h12) == 8'h00;
    endproperty
    property p_code_moves;
        seen_q && $changed(dac_code) |-> load_pulse;
    endproperty
    a_start_first: assert property (p_start_first)
        else $error("no start condition after request");
    a_idle_free: assert property (p_idle_free)
        else $error("bus not released while idle");
    a_slave_stable: assert property (p_slave_stable)
        else $error("loader moved data while clock high");
    a_stop_done: assert property (p_stop_done)
        else $error("stop not followed by done");
    a_write_ack_slot: assert property (p_write_ack_slot)
        else $error("loader pulled data outside ack slot");
    a_read_gives_way: assert property (p_read_gives_way)
        else $error("loader held data in master ack slot");
    a_load_slot: assert property (p_load_slot)
        else $error("load outside low byte ack fall");
    a_code_moves: assert property (p_code_moves)
        else $error("code changed without load");
endmodule

/* File: dv/tb_i2c_dac_code_loader.sv */
// Purpose: Self-checking bench joining master and loader ends
// Assumes: Serial clock made by the master divider from clk
// Notes: A full transfer takes about twelve thousand clk cycles
`timescale 1ns/1ns
module tb_i2c_dac_code_loader;
    typedef struct packed {
        logic rd;
        logic [6:0] addr;
        logic [7:0] ctrl;
        logic [15:0] code;
        logic [23:0] exp;
    } idl_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic slave_rst_n = 1'b0;
    logic address_select_pin = 1'b0;
    logic req = 1'b0;
    logic rd = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] ctrl = 8'h00;
    logic [15:0] code = 16'h0000;
    logic busy;
    logic done;
    logic ack_ok;
    logic load_pulse;
    logic [23:0] rd_data;
    logic [15:0] dac_code;
    logic [7:0] ctrl_byte;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int loads = 0;
    int base = 0;
    idl_row_t rows [2];
    idl_bus_if bus();
    idl_master i_idl_master (.bus(bus), .clk(clk), .rst_n(rst_n),
        .req(req), .rd(rd), .addr(addr), .ctrl(ctrl), .code(code),
        .busy(busy), .done(done), .ack_ok(ack_ok), .rd_data(rd_data));
    idl_slave i_idl_slave (.bus(bus), .rst_n(slave_rst_n),
        .address_select_pin(address_select_pin), .dac_code(dac_code),
        .ctrl_byte(ctrl_byte), .load_pulse(load_pulse));
    idl_asserts i_idl_asserts (.clk(clk), .rst_n(rst_n), .scl(bus.scl),
        .sda(bus.sda), .sda_oe_n_s(bus.sda_oe_n_s), .busy(busy),
        .done(done), .load_pulse(load_pulse), .dac_code(dac_code));
    always #4 clk = ~clk;
    always @(posedge load_pulse) loads++;
    task automatic final_report();
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Two full transfers near 12k cycles and two short ones fit here
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 45000)
        begin
            bad_count++;
            final_report();
        end
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t ns: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task automatic xfer(input idl_row_t r);
        int n;
        base = loads;
        @(posedge clk);
        req <= 1'b1;
        rd <= r.rd;
        addr <= r.addr;
        ctrl <= r.ctrl;
        code <= r.code;
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 15000)
        begin
            @(negedge clk);
            n++;
        end
        check({23'h0, done}, 24'h1);
    endtask
    initial
    begin
        rows[0] = '{1'b0, 7'h4D, 8'h10, 16'hFF80, 24'h10FF80};
        rows[1] = '{1'b1, 7'h4D, 8'h00, 16'h0000, 24'hFF8010};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Loader held in reset while a write to its own address runs
        xfer('{1'b0, 7'h4C, 8'h10, 16'hABCD, 24'h0});
        check({23'h0, ack_ok}, 24'h0);
        check({8'h00, dac_code}, 24'h0);
        @(posedge clk);
        slave_rst_n <= 1'b1;
        address_select_pin <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            xfer(rows[i]);
            check(rows[i].rd ? rd_data : {ctrl_byte, dac_code},
                rows[i].exp);
            check(24'(loads - base), {23'h0, !rows[i].rd});
            check({23'h0, ack_ok}, 24'h1);
        end
        // Select pin is high, so the plain address must be ignored
        xfer('{1'b0, 7'h4C, 8'h55, 16'h1234, 24'h0});
        check({23'h0, ack_ok}, 24'h0);
        check({ctrl_byte, dac_code}, 24'h10FF80);
        check(24'(loads - base), 24'h0);
        final_report();
    end
endmodule
